//--- rtl/lairq_regs.vh
// register offsets, field positions and reset values of the line alarm interrupt block
`ifndef LAIRQ_REGS_VH
`define LAIRQ_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LAIRQ_OFF_STATUS 12'h000
`define LAIRQ_OFF_EDGE 12'h004
`define LAIRQ_OFF_MASK 12'h008
`define LAIRQ_OFF_COND 12'h00c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LAIRQ_B_SYS_ALARM 7
`define LAIRQ_B_LINE_ALARM 6
`define LAIRQ_B_PATTERN 5
`define LAIRQ_B_IB_ACT 1
`define LAIRQ_B_IB_DEACT 0
`define LAIRQ_B_ALARM_SEL 6
`define LAIRQ_B_PATTERN_SEL 5
`define LAIRQ_B_IB_SEL 0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define LAIRQ_FLAG_MASK 8'he3
`define LAIRQ_EDGE_MASK 8'h61
`define LAIRQ_RST_STATUS 8'h00
`define LAIRQ_RST_EDGE 8'h00
`define LAIRQ_RST_MASK 8'he3

`endif

//--- rtl/lairq_edge_det.v
// edge qualifier for one condition bit
`timescale 1ns/1ps
module lairq_edge_det (
    input wire sys_clk,
    input wire sys_rst,
    input wire level_in,
    input wire both_edges,
    output wire event_pulse
);
    reg prev_ff;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_in;
        end
    end

    // rising only, or any change
    assign event_pulse = both_edges ? (level_in ^ prev_ff) : (level_in & ~prev_ff);
endmodule

//--- rtl/lairq_top.v
// line alarm interrupt status block with apb register access
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "lairq_regs.vh"
module lairq_top (
    input wire sys_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire system_alarm_state,
    input wire line_alarm_state,
    input wire pattern_sync_state,
    input wire inband_activate_state,
    input wire inband_deactivate_state,
    output wire irq_out
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    reg [4:0] cond_meta_ff;
    reg [4:0] cond_sync_ff;
    wire [4:0] cond_raw;

    assign cond_raw = {system_alarm_state, line_alarm_state, pattern_sync_state,
                       inband_activate_state, inband_deactivate_state};

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cond_meta_ff <= 5'h00;
            cond_sync_ff <= 5'h00;
        end else begin
            cond_meta_ff <= cond_raw;
            cond_sync_ff <= cond_meta_ff;
        end
    end

    // condition status laid out as the flag register
    wire [7:0] cond_status;
    assign cond_status = {cond_sync_ff[4:2], 3'h0, cond_sync_ff[1:0]};

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] interrupt_status_one_ff;
    reg [7:0] edge_select_register_ff;
    reg [7:0] irq_mask_ff;
    reg [7:0] nxt_status;
    wire [7:0] set_evt;

    wire alarm_edge_select;
    wire pattern_edge_select;
    wire inband_edge_select;
    assign alarm_edge_select = edge_select_register_ff[`LAIRQ_B_ALARM_SEL];
    assign pattern_edge_select = edge_select_register_ff[`LAIRQ_B_PATTERN_SEL];
    assign inband_edge_select = edge_select_register_ff[`LAIRQ_B_IB_SEL];

    // ----------------------------------------------------------------
    // edge qualifiers
    // ----------------------------------------------------------------
    lairq_edge_det u_sys_alarm (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(cond_status[`LAIRQ_B_SYS_ALARM]),
        .both_edges(alarm_edge_select),
        .event_pulse(set_evt[7])
    );

    lairq_edge_det u_line_alarm (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(cond_status[`LAIRQ_B_LINE_ALARM]),
        .both_edges(alarm_edge_select),
        .event_pulse(set_evt[6])
    );

    lairq_edge_det u_pattern (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(cond_status[`LAIRQ_B_PATTERN]),
        .both_edges(pattern_edge_select),
        .event_pulse(set_evt[5])
    );

    lairq_edge_det u_ib_act (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(cond_status[`LAIRQ_B_IB_ACT]),
        .both_edges(inband_edge_select),
        .event_pulse(set_evt[1])
    );

    lairq_edge_det u_ib_deact (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(cond_status[`LAIRQ_B_IB_DEACT]),
        .both_edges(inband_edge_select),
        .event_pulse(set_evt[0])
    );

    assign set_evt[4:2] = 3'h0;

    // ----------------------------------------------------------------
    // apb access
    // ----------------------------------------------------------------
    wire wr_en;
    wire rd_en;
    wire addr_hit;
    wire [7:0] clr_mask;

    // zero wait state: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_hit = (paddr == `LAIRQ_OFF_STATUS) || (paddr == `LAIRQ_OFF_EDGE) ||
                      (paddr == `LAIRQ_OFF_MASK) || (paddr == `LAIRQ_OFF_COND);
    assign pslverr = psel & penable & ~addr_hit;
    assign clr_mask = (wr_en && paddr == `LAIRQ_OFF_STATUS) ?
                      (pwdata[7:0] & `LAIRQ_FLAG_MASK) : 8'h00;

    // set wins over a clear in the same cycle so no event is lost
    always @* begin
        nxt_status = ((interrupt_status_one_ff & ~clr_mask) | set_evt) & `LAIRQ_FLAG_MASK;
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            interrupt_status_one_ff <= `LAIRQ_RST_STATUS;
            edge_select_register_ff <= `LAIRQ_RST_EDGE;
            irq_mask_ff <= `LAIRQ_RST_MASK;
        end else begin
            interrupt_status_one_ff <= nxt_status;
            if (wr_en && paddr == `LAIRQ_OFF_EDGE) begin
                edge_select_register_ff <= pwdata[7:0] & `LAIRQ_EDGE_MASK;
            end
            if (wr_en && paddr == `LAIRQ_OFF_MASK) begin
                irq_mask_ff <= pwdata[7:0] & `LAIRQ_FLAG_MASK;
            end
        end
    end

    // read data registered during the setup cycle so it is stable in access
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `LAIRQ_OFF_STATUS: prdata <= {24'h000000, interrupt_status_one_ff};
                `LAIRQ_OFF_EDGE: prdata <= {24'h000000, edge_select_register_ff};
                `LAIRQ_OFF_MASK: prdata <= {24'h000000, irq_mask_ff};
                `LAIRQ_OFF_COND: prdata <= {24'h000000, cond_status};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    // mask resets to all enabled so any flag raises the pin by default
    assign irq_out = |(interrupt_status_one_ff & irq_mask_ff);
endmodule

//--- sim/lairq_asserts.sv
// port checks for the line alarm interrupt block
`timescale 1ns/1ps
module lairq_asserts (
    input wire sys_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq_out
);
    wire acc = psel && penable;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ready_high_a: assert property (pready) else $error("pready low");
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !irq_out && prdata == 0)
        else $error("not quiet after reset");
    bad_addr_a: assert property (acc && paddr > 12'h00c |-> pslverr) else $error("no pslverr");
    err_phase_a: assert property (pslverr |-> acc) else $error("stray pslverr");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 0)
        else $error("upper read bits");
    rsvd_zero_a: assert property (acc && !pwrite && paddr == 0 |-> prdata[4:2] == 0)
        else $error("reserved bits set");
    irq_flags_a: assert property (acc && !pwrite && paddr == 0 && prdata[7:0] == 0
        |-> !$past(irq_out)) else $error("irq without flag");
    irq_fall_a: assert property ($fell(irq_out) |-> $past(acc && pwrite) || $past(sys_rst))
        else $error("irq fell without write");
endmodule
bind lairq_top lairq_asserts chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq_out));

//--- sim/lairq_host.sv
// apb master standing in for the host processor
`timescale 1ns/1ps
module lairq_host (
    input wire sys_clk,
    input wire pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

//--- sim/tb.sv
// self-checking bench for the line alarm interrupt block
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cnd = 8'h00;
    logic [7:0] m;
    wire psel, penable, pwrite, pready, pslverr, irq_out;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] exp_q[$];
    int bits[5] = '{7, 6, 5, 1, 0};
    initial forever #25 sys_clk = ~sys_clk;
    lairq_host host (.sys_clk(sys_clk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    lairq_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .system_alarm_state(cnd[7]), .line_alarm_state(cnd[6]),
        .pattern_sync_state(cnd[5]), .inband_activate_state(cnd[1]),
        .inband_deactivate_state(cnd[0]), .irq_out(irq_out));
    task automatic fail(input string s);
        errors++;
        $display("ERROR %0t %s", $time, s);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'($urandom), d});
    endtask
    task automatic irq(input logic e);
        #1;
        tests_run++;
        if (irq_out !== e) fail("irq level");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            tests_run++;
            if (exp_q.size() == 0 || prdata !== exp_q.pop_front()) fail("read data");
        end
    end
    initial begin
        void'($urandom(32'heb2e4f9d));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(12'h000, 32'h0);
        rd(12'h008, 32'he3);
        rd(12'h004, 32'h0);
        rd(12'h010, 32'h0);
        for (int s = 0; s < 2; s++) begin
            wr(12'h004, s ? 8'h61 : 8'h00);
            foreach (bits[i]) begin
                m = 8'h01 << bits[i];
                @(posedge sys_clk) cnd[bits[i]] <= 1'b1;
                repeat (6) @(posedge sys_clk);
                irq(1'b1);
                rd(12'h00c, {24'h0, m});
                wr(12'h008, 8'h00);
                irq(1'b0);
                wr(12'h008, 8'he3);
                wr(12'h000, 8'h1c);
                rd(12'h000, {24'h0, m});
                wr(12'h000, m);
                rd(12'h000, 32'h0);
                @(posedge sys_clk) cnd[bits[i]] <= 1'b0;
                repeat (6) @(posedge sys_clk);
                rd(12'h000, s ? {24'h0, m} : 32'h0);
                wr(12'h000, 8'hff);
            end
        end
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end
endmodule
